//--- ssc_standby_ctrl.sv
// standby mode sequencer, request flags, nest status and shared-vector handling
// assumes cpu pulses come from pclk logic; pin inputs are asynchronous and synchronised here
//
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module ssc_standby_ctrl
  import ssc_pkg::*;
#(
  parameter int WAIT_20_CYC = 2**20,
  parameter int WAIT_17_CYC = 2**17,
  parameter int WAIT_15_CYC = 2**15,
  parameter int WAIT_13_CYC = 2**13,
  parameter int RESET_WAIT_CYC = 2**17,
  parameter int CLK_LAG_CYC = 4
)
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  // cpu instruction events
  input wire logic stop_instr,
  input wire logic halt_instr,
  input wire logic irq_accept,
  input wire logic shared_accept,
  // on-chip request sources
  input wire logic interval_timer_irq,
  input wire logic watch_timer_irq,
  // asynchronous pins
  input wire logic shared_edge_irq,
  input wire logic ext_irq_zero,
  input wire logic ext_irq_one,
  input wire logic test_input_irq,
  // clock and peripheral control
  output logic cpu_clk_en,
  output logic [1:0] cpu_clk_sel,
  output logic main_osc_en,
  output logic crystal_in_gnd,
  output logic interval_timer_run,
  output logic main_periph_run,
  output logic watch_sub_only,
  output logic ext_irq_zero_en,
  // interrupt side
  output logic [NUM_SRC-1:0] interval_timer_request_flag,
  output logic shared_irq_req,
  output logic wake_vector,
  output logic accept_all,
  output logic accept_high_only
);

  typedef struct packed {
    ssc_state_e st;
    logic [CNT_W-1:0] cnt;
    logic [1:0] clk_sel;
    logic [1:0] clk_act;
    logic [LAG_W-1:0] lag;
    logic [1:0] nest;
    logic mie;
    logic [3:0] wsel;
    logic [NUM_SRC-1:0] en;
    logic [NUM_SRC-1:0] req;
    logic [NUM_PIN-1:0] sync1;
    logic [NUM_PIN-1:0] sync2;
    logic [NUM_PIN-1:0] prev;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic cpu_clk_en;
    logic main_osc_en;
    logic xtal_gnd;
    logic bt_run;
    logic main_run;
    logic watch_sub;
    logic irq0_en;
    logic shared_req;
    logic wake_vec;
    logic acc_all;
    logic acc_high;
  } ssc_regs_s;

  ssc_regs_s r_q;
  ssc_regs_s r_d;

  localparam ssc_regs_s REGS_RST = '{
    st: ST_SETTLE,
    cnt: CNT_W'(RESET_WAIT_CYC - 1),
    clk_sel: PCC_CLK_RST,
    clk_act: PCC_CLK_RST,
    wsel: WAIT_SEL_RST,
    main_osc_en: 1'b1,
    irq0_en: 1'b1,
    acc_all: 1'b1,
    default: '0
  };

  // stop-release wait chosen by the low three select bits; prohibited codes take the longest
  function automatic logic [CNT_W-1:0] wake_wait(input logic [3:0] sel);
    logic [CNT_W-1:0] w;
    w = CNT_W'(WAIT_20_CYC - 1);
    case (sel[2:0])
      3'h3: w = CNT_W'(WAIT_17_CYC - 1);
      3'h5: w = CNT_W'(WAIT_15_CYC - 1);
      3'h7: w = CNT_W'(WAIT_13_CYC - 1);
      default: w = CNT_W'(WAIT_20_CYC - 1);
    endcase
    return w;
  endfunction

  logic setup;
  logic wr;
  logic mapped;
  logic standby;
  logic [NUM_SRC-1:0] set_ev;
  logic [NUM_SRC-1:0] clr_sw;
  logic [NUM_SRC-1:0] clr_hw;
  logic [NUM_SRC-1:0] live;
  logic pending;
  logic stop_ok;
  logic [NUM_PIN-1:0] rise;

  always_comb
  begin
    r_d = r_q;
    setup = psel && !penable;
    wr = psel && penable && r_q.pready && pwrite;
    mapped = (paddr == ADDR_PCC) || (paddr == ADDR_NEST) || (paddr == ADDR_WAIT)
      || (paddr == ADDR_IRQ_EN) || (paddr == ADDR_IRQ_REQ) || (paddr == ADDR_STAT);
    standby = (r_q.st == ST_HALT) || (r_q.st == ST_STOP);

    // pin synchronisers; edges are taken only past the second stage
    r_d.sync1 = {test_input_irq, ext_irq_one, ext_irq_zero, shared_edge_irq};
    r_d.sync2 = r_q.sync1;
    r_d.prev = r_q.sync2;
    rise = r_q.sync2 & ~r_q.prev;

    set_ev = '0;
    set_ev[SRC_BT] = interval_timer_irq && r_q.bt_run;
    set_ev[SRC_SHARED] = rise[0];
    set_ev[SRC_EXT0] = rise[1] && !standby;
    set_ev[SRC_EXT1] = rise[2];
    set_ev[SRC_TEST] = rise[3];
    set_ev[SRC_WATCH] = watch_timer_irq;

    // apb: zero-wait access, answer registered in the setup cycle
    r_d.pready = setup;
    r_d.pslverr = setup && !mapped;
    r_d.prdata = '0;
    if (setup)
    begin
      case (paddr)
        ADDR_PCC: r_d.prdata = {28'h0, r_q.st == ST_STOP, r_q.st == ST_HALT, r_q.clk_sel};
        ADDR_NEST: r_d.prdata = {29'h0, r_q.mie, r_q.nest};
        ADDR_WAIT: r_d.prdata = {28'h0, r_q.wsel};
        ADDR_IRQ_EN: r_d.prdata = {26'h0, r_q.en};
        ADDR_IRQ_REQ: r_d.prdata = {26'h0, r_q.req};
        ADDR_STAT: r_d.prdata = {26'h0, r_q.clk_act, r_q.st};
        default: r_d.prdata = '0;
      endcase
    end

    clr_sw = '0;
    if (wr)
    begin
      case (paddr)
        ADDR_PCC: r_d.clk_sel = pwdata[1:0];
        ADDR_NEST:
        begin
          r_d.nest = pwdata[1:0];
          r_d.mie = pwdata[NEST_MIE_BIT];
        end
        ADDR_WAIT: r_d.wsel = pwdata[3:0];
        ADDR_IRQ_EN: r_d.en = pwdata[NUM_SRC-1:0];
        ADDR_IRQ_REQ: clr_sw = pwdata[NUM_SRC-1:0];
        default: r_d.wsel = r_q.wsel;
      endcase
    end

    // acceptance advances the nest level; hardware wins over a software write
    if (irq_accept)
    begin
      case (r_q.nest)
        2'h0: r_d.nest = 2'h1;
        2'h1: r_d.nest = 2'h2;
        default: r_d.nest = r_q.nest;
      endcase
    end

    // shared vector: clear only when the source is unambiguous
    clr_hw = '0;
    if (shared_accept)
    begin
      if (r_q.en[SRC_BT] && !r_q.en[SRC_SHARED])
        clr_hw[SRC_BT] = 1'b1;
      else if (r_q.en[SRC_SHARED] && !r_q.en[SRC_BT])
        clr_hw[SRC_SHARED] = 1'b1;
    end
    // with both enabled nothing is cleared here

    // set wins over any clear in the same cycle
    r_d.req = (r_q.req & ~clr_sw & ~clr_hw) | set_ev;

    // clock select lag
    if (r_q.clk_sel != r_q.clk_act)
    begin
      if (r_q.lag == LAG_W'(CLK_LAG_CYC - 1))
      begin
        r_d.clk_act = r_q.clk_sel;
        r_d.lag = '0;
      end
      else
        r_d.lag = r_q.lag + 1'b1;
    end
    else
      r_d.lag = '0;

    live = r_q.req & r_q.en;
    pending = |live;
    stop_ok = (r_q.clk_act != CLKSEL_SUB) && (r_q.clk_sel == r_q.clk_act);
    r_d.wake_vec = 1'b0;

    case (r_q.st)
      ST_RUN:
      begin
        if (stop_instr && stop_ok)
        begin
          if (pending)
          begin
            r_d.st = ST_SETTLE;
            r_d.cnt = wake_wait(r_q.wsel);
          end
          else
            r_d.st = ST_STOP;
        end
        else if (halt_instr && !pending)
          r_d.st = ST_HALT;
        // a halt with an enabled request pending is released at once
      end
      ST_HALT:
      begin
        if (pending)
        begin
          r_d.st = ST_RUN;
          r_d.wake_vec = r_q.mie && |(live & ~NOVEC_MASK);
        end
      end
      ST_STOP:
      begin
        if (pending)
        begin
          r_d.st = ST_SETTLE;
          r_d.cnt = wake_wait(r_q.wsel);
        end
      end
      ST_SETTLE:
      begin
        if (r_q.cnt == '0)
        begin
          r_d.st = ST_RUN;
          r_d.wake_vec = r_q.mie && |(live & ~NOVEC_MASK);
        end
        else
          r_d.cnt = r_q.cnt - 1'b1;
      end
      default: r_d.st = ST_SETTLE;
    endcase

    // outputs follow the next state so they leave flops in step with it
    r_d.cpu_clk_en = (r_d.st == ST_RUN);
    r_d.main_osc_en = (r_d.st != ST_STOP);
    r_d.xtal_gnd = (r_d.st == ST_STOP);
    r_d.bt_run = (r_d.st != ST_STOP);
    r_d.main_run = (r_d.st != ST_STOP);
    r_d.watch_sub = (r_d.st == ST_STOP);
    r_d.irq0_en = (r_d.st != ST_HALT) && (r_d.st != ST_STOP);
    // either enabled flag raises the shared request; the and reading would hide single events
    r_d.shared_req = |(r_d.req[SRC_SHARED:SRC_BT] & r_d.en[SRC_SHARED:SRC_BT]);
    r_d.acc_all = (r_d.nest == 2'h0);
    r_d.acc_high = (r_d.nest == 2'h1);
  end

  // registers, masks and flags carry over standby untouched
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      r_q <= REGS_RST;
    else
      r_q <= r_d;
  end

  assign pready = r_q.pready;
  assign pslverr = r_q.pslverr;
  assign prdata = r_q.prdata;
  assign cpu_clk_en = r_q.cpu_clk_en;
  assign cpu_clk_sel = r_q.clk_act;
  assign main_osc_en = r_q.main_osc_en;
  assign crystal_in_gnd = r_q.xtal_gnd;
  assign interval_timer_run = r_q.bt_run;
  assign main_periph_run = r_q.main_run;
  assign watch_sub_only = r_q.watch_sub;
  assign ext_irq_zero_en = r_q.irq0_en;
  assign interval_timer_request_flag = r_q.req;
  assign shared_irq_req = r_q.shared_req;
  assign wake_vector = r_q.wake_vec;
  assign accept_all = r_q.acc_all;
  assign accept_high_only = r_q.acc_high;

endmodule
`default_nettype wire

//--- ssc_pkg.sv
// constants, register map and types for the standby and shared-interrupt controller
// assumes an apb master on pclk and a cpu core that reports instructions as one-cycle pulses
// Operation
// - stop instruction sets control bit 3, halt instruction sets bit 2
// - stop only from main clock; halt from main or subsystem clock
// - stop halts only the main oscillator; subsystem clock keeps running
// - halt gates only the cpu clock; no instructions execute in standby
// - interval timer stops in stop mode, keeps counting and flagging in halt
// - in stop only external-clocked peripherals and subclock watch timer run
// - in halt main-clock peripherals run while main clock runs; watch continues
// - external input zero disabled in standby; inputs one, two, four stay live
// - standby ends on reset or on an enabled hardware request only
// - registers, flags, latches and memory hold their contents through standby
// - an enabled pending request at entry releases standby at once
// - stop with enabled pending request becomes halt, then resumes after wake wait
// - clock select in low two bits; change applies after lag
// - stop ties the crystal input to ground internally
// - with one shared source enabled, acceptance clears that source's flag
// - with both shared sources enabled, flags combine into one shared request
// - with both shared sources enabled, acceptance leaves both flags alone
// - writing both nest status bits to zero restores normal-program status
// - status 0 all, 1 high-order only, 2 none; acceptance advances one level
// - wake with enable clear resumes; with it set vector unless watch or test
// - stop released by interrupt holds cpu for the selected settling wait
package ssc_pkg;

  // register byte offsets
  localparam logic [7:0] ADDR_PCC = 8'h00;
  localparam logic [7:0] ADDR_NEST = 8'h04;
  localparam logic [7:0] ADDR_WAIT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_REQ = 8'h10;
  localparam logic [7:0] ADDR_STAT = 8'h14;

  // power/clock control fields
  localparam int PCC_HALT_BIT = 2;
  localparam int PCC_STOP_BIT = 3;
  localparam logic [1:0] CLKSEL_SUB = 2'h3;

  // nest register fields
  localparam int NEST_MIE_BIT = 2;

  // request/enable bit positions
  localparam int NUM_SRC = 6;
  localparam int SRC_BT = 0;
  localparam int SRC_SHARED = 1;
  localparam int SRC_EXT0 = 2;
  localparam int SRC_EXT1 = 3;
  localparam int SRC_TEST = 4;
  localparam int SRC_WATCH = 5;
  localparam int NUM_PIN = 4;
  localparam logic [NUM_SRC-1:0] NOVEC_MASK = 6'h30;

  // reset values and counter widths
  localparam logic [1:0] PCC_CLK_RST = 2'h0;
  localparam logic [3:0] WAIT_SEL_RST = 4'h0;
  localparam int CNT_W = 21;
  localparam int LAG_W = 4;

  typedef enum logic [3:0] {
    ST_RUN = 4'h1,
    ST_HALT = 4'h2,
    ST_STOP = 4'h4,
    ST_SETTLE = 4'h8
  } ssc_state_e;

endpackage

//--- ssc_standby_ctrl_asserts.sv
// concurrent checks on the standby controller ports
// assumes a single pclk domain and the asynchronous active-low presetn
`timescale 1ns/1ps
`default_nettype none
module ssc_standby_ctrl_asserts
  import ssc_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  // cpu events
  input wire logic stop_instr,
  input wire logic halt_instr,
  input wire logic irq_accept,
  // controls
  input wire logic cpu_clk_en,
  input wire logic [1:0] cpu_clk_sel,
  input wire logic main_osc_en,
  input wire logic crystal_in_gnd,
  input wire logic interval_timer_run,
  input wire logic main_periph_run,
  input wire logic watch_sub_only,
  input wire logic ext_irq_zero_en,
  input wire logic wake_vector,
  input wire logic accept_all,
  input wire logic accept_high_only
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  stop_entry_a: assert property (stop_instr && cpu_clk_en && cpu_clk_sel != CLKSEL_SUB |=> !cpu_clk_en)
    else $error("stop pulse left the cpu clock running");
  sub_stop_a: assert property (stop_instr && cpu_clk_en && cpu_clk_sel == CLKSEL_SUB |=> main_osc_en)
    else $error("stop accepted while on subsystem clock");
  stop_gate_a: assert property (!main_osc_en |-> crystal_in_gnd && !main_periph_run && watch_sub_only)
    else $error("stop mode gating wrong");
  halt_gate_a: assert property (halt_instr && cpu_clk_en && !stop_instr |=> main_osc_en && !crystal_in_gnd)
    else $error("halt stopped the oscillator");
  bt_halt_a: assert property (main_osc_en && !cpu_clk_en && $past(cpu_clk_en) |-> interval_timer_run)
    else $error("interval timer stopped in halt");
  ext0_off_a: assert property (!main_osc_en |-> !ext_irq_zero_en)
    else $error("input zero live in stop");
  nest_step_a: assert property (irq_accept && accept_all |=> accept_high_only && !accept_all)
    else $error("nest status did not advance from 0");
  nest_top_a: assert property (irq_accept && accept_high_only |=> !accept_all && !accept_high_only)
    else $error("nest status did not advance from 1");
  settle_hold_a: assert property ($rose(main_osc_en) |-> !cpu_clk_en ##1 !cpu_clk_en)
    else $error("cpu ran before settling wait");
  clk_lag_a: assert property (psel && penable && pready && pwrite && paddr == ADDR_PCC |=> $stable(cpu_clk_sel))
    else $error("clock select changed without lag");
  wake_vec_a: assert property (wake_vector |-> cpu_clk_en ##1 !wake_vector)
    else $error("wake vector pulse wrong");

  cover property (halt_instr ##1 !cpu_clk_en);
  cover property ($fell(main_osc_en));
  cover property (wake_vector);
endmodule

bind ssc_standby_ctrl ssc_standby_ctrl_asserts chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .stop_instr(stop_instr), .halt_instr(halt_instr), .irq_accept(irq_accept), .cpu_clk_en(cpu_clk_en),
  .cpu_clk_sel(cpu_clk_sel), .main_osc_en(main_osc_en), .crystal_in_gnd(crystal_in_gnd),
  .interval_timer_run(interval_timer_run), .main_periph_run(main_periph_run),
  .watch_sub_only(watch_sub_only), .ext_irq_zero_en(ext_irq_zero_en), .wake_vector(wake_vector),
  .accept_all(accept_all), .accept_high_only(accept_high_only));
`default_nettype wire

//--- ssc_far_side.sv
// cpu core and interrupt source model: instruction pulses, timer ticks, pin edges
// assumes the bench calls its tasks one at a time
`timescale 1ns/1ps
`default_nettype none
module ssc_far_side (
  // clock
  input wire logic pclk,
  // pins: shared edge, ext zero, ext one, test
  output logic [3:0] pins,
  // events: stop, halt, accept, shared accept, interval tick, watch tick
  output logic [5:0] ev
);
  initial
  begin
    pins = 4'h0;
    ev = 6'h00;
  end

  // pin held two cycles so the synchroniser cannot miss it
  task automatic pin_edge(input int i);
    @(posedge pclk);
    pins[i] <= 1'b1;
    repeat (2) @(posedge pclk);
    pins[i] <= 1'b0;
  endtask

  // one-cycle pulse; the next call starts a clock later, like the nop after an entry
  task automatic pulse(input int i);
    @(posedge pclk);
    ev[i] <= 1'b1;
    @(posedge pclk);
    ev[i] <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- standby_and_shared_irq_control_bench.sv
// self-checking bench for the standby and shared-interrupt controller
// assumes short wait parameters; far side model drives cpu events and pins
`timescale 1ns/1ps
`default_nettype none
module standby_and_shared_irq_control_bench;
  import ssc_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, cpu_clk_en, main_osc_en, crystal_in_gnd, shared_irq_req, wake_vector;
  logic accept_all, accept_high_only, ext_irq_zero_en, bt_run, periph_run, watch_sub;
  logic [1:0] clk_sel_eff;
  logic [5:0] req_flags;
  logic [3:0] pins, sel;
  logic [3:0] codes [5] = '{4'h0, 4'h1, 4'h3, 4'h5, 4'h7};
  logic [5:0] ev;
  int err_count = 0, n_compared = 0, seed = 76731, n;

  always #5 pclk = ~pclk;

  ssc_far_side far_u (.pclk(pclk), .pins(pins), .ev(ev));
  ssc_standby_ctrl #(.WAIT_20_CYC(40), .WAIT_17_CYC(30), .WAIT_15_CYC(20), .WAIT_13_CYC(10),
    .RESET_WAIT_CYC(16), .CLK_LAG_CYC(2)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .stop_instr(ev[0]), .halt_instr(ev[1]), .irq_accept(ev[2]),
    .shared_accept(ev[3]), .interval_timer_irq(ev[4]), .watch_timer_irq(ev[5]),
    .shared_edge_irq(pins[0]), .ext_irq_zero(pins[1]), .ext_irq_one(pins[2]), .test_input_irq(pins[3]),
    .cpu_clk_en(cpu_clk_en), .cpu_clk_sel(clk_sel_eff), .main_osc_en(main_osc_en),
    .crystal_in_gnd(crystal_in_gnd), .interval_timer_run(bt_run), .main_periph_run(periph_run),
    .watch_sub_only(watch_sub), .ext_irq_zero_en(ext_irq_zero_en),
    .interval_timer_request_flag(req_flags), .shared_irq_req(shared_irq_req), .wake_vector(wake_vector),
    .accept_all(accept_all), .accept_high_only(accept_high_only));

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge pclk);
    #1;
  endtask

  task automatic wait_run();
    while (cpu_clk_en !== 1'b1) tick(1);
  endtask

  function automatic int wlen(input logic [3:0] s);
    case (s[2:0])
      3'h3: return 30;
      3'h5: return 20;
      3'h7: return 10;
      default: return 40;
    endcase
  endfunction

  initial
  begin
    #400000;
    err_count++;
    give_verdict();
  end

  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    n = 0;
    while (cpu_clk_en !== 1'b1)
    begin
      tick(1);
      n++;
    end
    // settle counter is loaded with the wait minus one and releases on the edge after it hits zero
    chk("reset wait", n, 16);
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped err", er, 1'b1);
    apb(1'b1, ADDR_NEST, 32'h1);
    apb(1'b1, ADDR_IRQ_EN, 32'h0c);
    apb(1'b1, ADDR_IRQ_REQ, 32'h3f);
    far_u.pulse(1);
    tick(1);
    chk("halt clk", cpu_clk_en, 1'b0);
    chk("ext0 en", ext_irq_zero_en, 1'b0);
    chk("bt run halt", bt_run, 1'b1);
    chk("periph halt", periph_run, 1'b1);
    far_u.pin_edge(1);
    far_u.pulse(4);
    tick(6);
    chk("no wake", cpu_clk_en, 1'b0);
    far_u.pin_edge(2);
    wait_run();
    apb(1'b0, ADDR_IRQ_REQ, 32'h0);
    chk("flags held", rd, 32'h09);
    chk("flag port", req_flags, 6'h09);
    apb(1'b0, ADDR_NEST, 32'h0);
    chk("nest kept", rd, 32'h1);
    far_u.pulse(1);
    tick(2);
    chk("halt pending", cpu_clk_en, 1'b1);
    far_u.pulse(0);
    tick(1);
    chk("stop pending osc", main_osc_en, 1'b1);
    wait_run();
    apb(1'b1, ADDR_IRQ_REQ, 32'h3f);
    apb(1'b1, ADDR_PCC, {30'h0, CLKSEL_SUB});
    tick(4);
    chk("clk sel", clk_sel_eff, CLKSEL_SUB);
    far_u.pulse(0);
    tick(1);
    chk("sub stop", cpu_clk_en, 1'b1);
    apb(1'b1, ADDR_PCC, 32'h0);
    tick(4);
    for (int i = 0; i < 6; i++)
    begin
      sel = (i < 5) ? codes[i] : 4'($random(seed));
      apb(1'b1, ADDR_WAIT, {28'h0, sel});
      far_u.pulse(0);
      tick(1);
      chk("osc off", main_osc_en, 1'b0);
      chk("xtal gnd", crystal_in_gnd, 1'b1);
      chk("bt stop", bt_run, 1'b0);
      chk("periph stop", periph_run, 1'b0);
      chk("watch sub", watch_sub, 1'b1);
      far_u.pin_edge(2);
      while (main_osc_en !== 1'b1) tick(1);
      n = 0;
      while (cpu_clk_en !== 1'b1)
      begin
        tick(1);
        n++;
      end
      chk("wake wait", n, wlen(sel));
      apb(1'b1, ADDR_IRQ_REQ, 32'h3f);
    end
    apb(1'b1, ADDR_IRQ_EN, 32'h01);
    far_u.pulse(4);
    tick(2);
    chk("shared req", shared_irq_req, 1'b1);
    far_u.pulse(3);
    tick(2);
    apb(1'b0, ADDR_IRQ_REQ, 32'h0);
    chk("single clear", rd, 32'h0);
    apb(1'b1, ADDR_IRQ_EN, 32'h03);
    far_u.pulse(4);
    far_u.pin_edge(0);
    far_u.pulse(3);
    tick(2);
    apb(1'b0, ADDR_IRQ_REQ, 32'h0);
    chk("both kept", rd, 32'h03);
    apb(1'b1, ADDR_IRQ_REQ, 32'h3f);
    apb(1'b1, ADDR_NEST, 32'h0);
    far_u.pulse(2);
    far_u.pulse(2);
    tick(1);
    chk("nest top", {accept_all, accept_high_only}, 2'h0);
    apb(1'b1, ADDR_NEST, 32'h4);
    tick(1);
    chk("nest zero", accept_all, 1'b1);
    apb(1'b1, ADDR_IRQ_EN, 32'h08);
    far_u.pulse(1);
    far_u.pin_edge(2);
    wait_run();
    chk("vector", wake_vector, 1'b1);
    give_verdict();
  end
endmodule
`default_nettype wire
